// file: bench/host_port_props.sv
// Assertions on the host port link pins
`timescale 1ns/10ps
module host_port_props (
   // Link pins
   input wire logic clk,
   input wire logic rst,
   input wire logic split_bus_mode_select,
   input wire logic frame_n,
   input wire logic wr_rd_host_oe,
   input wire logic wr_rd_dev_oe,
   input wire logic par_out,
   input wire logic par_oe,
   input wire logic inta_oe,
   input wire logic inta_n_line,
   input wire logic [3:0] cbe,
   input wire logic [31:0] ad
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Mode pin must have held past the device sync delay before parity is judged
   par_split_a: assert property (split_bus_mode_select && $past(split_bus_mode_select, 4) |-> par_oe && !par_out)
      else $error("parity not held low in split mode");
   par_pci_a: assert property (!split_bus_mode_select && !$past(split_bus_mode_select, 4) && par_oe
      |-> par_out == ^{ad, cbe}) else $error("parity value wrong");
   par_once_a: assert property (!split_bus_mode_select && !$past(split_bus_mode_select, 4) && par_oe
      |=> !par_oe) else $error("parity driven too long");
   wrrd_float_a: assert property (!wr_rd_dev_oe) else $error("write/read driven by controller");
   wrrd_drive_a: assert property (!frame_n && split_bus_mode_select |-> wr_rd_host_oe)
      else $error("write/read not driven on split access");
   inta_drain_a: assert property (inta_oe |-> !inta_n_line) else $error("interrupt line not low");
   inta_free_a: assert property (!inta_oe |-> inta_n_line) else $error("interrupt line not released");
   frame_gap_a: assert property ($fell(frame_n) |=> frame_n [*5]) else $error("access too long or too close");
   cover property (!frame_n && split_bus_mode_select);
   cover property (par_oe && !split_bus_mode_select);
   cover property ($rose(inta_oe));
endmodule // host_port_props

// file: bench/tb_host_bus_mode_and_irq_pins.sv
// Bench joining the controller and host ends of the host port
`timescale 1ns/10ps
module tb_host_bus_mode_and_irq_pins;
   logic clk, rst, cfg_split, cfg_test, cfg_bscan_on, req_valid, req_write, req_cfg, req_ready;
   logic irq_seen, par_error, split_mode, test_mode, bscan_enable, acc_valid, acc_cfg, acc_write;
   logic [31:0] req_addr, acc_addr;
   logic [7:0] irq_event, irq_mask, irq_ack, irq_pending;
   int err_count = 0;
   int compares = 0;
   int w;
   host_port_if u_link (.clk(clk), .rst(rst));
   host_port_dev u_host_port_dev (.clk(clk), .rst(rst), .pins(u_link.dev), .irq_event(irq_event),
      .irq_mask(irq_mask), .irq_ack(irq_ack), .irq_pending(irq_pending), .split_mode(split_mode),
      .test_mode(test_mode), .bscan_enable(bscan_enable), .acc_valid(acc_valid), .acc_cfg(acc_cfg),
      .acc_write(acc_write), .acc_addr(acc_addr));
   host_port_host u_host_port_host (.clk(clk), .rst(rst), .pins(u_link.host), .cfg_split(cfg_split),
      .cfg_test(cfg_test), .cfg_bscan_on(cfg_bscan_on), .req_valid(req_valid), .req_write(req_write),
      .req_cfg(req_cfg), .req_addr(req_addr), .req_ready(req_ready), .irq_seen(irq_seen),
      .par_error(par_error));
   host_port_props u_host_port_props (.clk(clk), .rst(rst), .frame_n(u_link.frame_n),
      .split_bus_mode_select(u_link.split_bus_mode_select), .wr_rd_host_oe(u_link.wr_rd_host_oe),
      .wr_rd_dev_oe(u_link.wr_rd_dev_oe), .par_out(u_link.par_out), .par_oe(u_link.par_oe),
      .inta_oe(u_link.inta_oe), .inta_n_line(u_link.inta_n_line), .cbe(u_link.cbe), .ad(u_link.ad));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic tally_and_finish;
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic test_modes;
      for (int i = 0; i < 8; i++) begin
         {cfg_split, cfg_test, cfg_bscan_on} = 3'(i);
         step(8);
         check("split_mode", split_mode, cfg_split);
         check("test_mode", test_mode, cfg_test);
         check("bscan_enable", bscan_enable, cfg_bscan_on);
      end
      $display("test_modes done");
   endtask

   // Back to back accesses, every direction and space, in one mode
   task automatic test_access(input logic split);
      {cfg_split, cfg_test, cfg_bscan_on} = {split, 2'h0};
      step(8);
      for (int i = 0; i < 4; i++) begin
         w = 0;
         while (req_ready !== 1'h1 && w < 20) begin
            w++;
            step(1);
         end
         check("req_ready", req_ready, 1);
         {req_valid, req_write, req_cfg} = {1'h1, i[1:0]};
         req_addr = 32'hC3A5_0F08 + 32'(i << 28);
         step(1);
         req_valid = 1'h0;
         w = 0;
         while (acc_valid !== 1'h1 && w < 10) begin
            w++;
            step(1);
         end
         check("acc_valid", acc_valid, 1);
         check("acc_cfg", acc_cfg, i[0]);
         check("acc_write", acc_write, i[1]);
         check("acc_addr", acc_addr, req_addr);
         check("wr_rd_line", u_link.wr_rd_line, split ? i[1] : 1'h1);
         step(3);
         check("par_error", par_error, 0);
      end
      $display("test_access done");
   endtask

   task automatic test_irq;
      irq_mask = 8'h01;
      irq_event = 8'h01;
      step(1);
      irq_event = 8'h00;
      check("masked", u_link.inta_n_line, 1);
      // Raise mid-cycle so a clocked output would still be idle here
      #5;
      irq_event = 8'h06;
      #1;
      check("async", u_link.inta_n_line, 0);
      step(1);
      irq_event = 8'h00;
      irq_ack = 8'h02;
      step(3);
      irq_ack = 8'h00;
      check("irq_seen", irq_seen, 1);
      check("pending", irq_pending, 8'h05);
      check("held", u_link.inta_n_line, 0);
      irq_ack = 8'h04;
      step(1);
      check("released", u_link.inta_n_line, 1);
      irq_mask = 8'h00;
      #1;
      check("unmasked", u_link.inta_n_line, 0);
      step(1);
      // Event and acknowledge of one source in the same cycle: the event wins
      {irq_event, irq_ack} = {8'h02, 8'h02};
      step(1);
      check("set_wins", irq_pending, 8'h03);
      {irq_event, irq_ack} = {8'h00, 8'hFF};
      step(1);
      irq_ack = 8'h00;
      check("cleared", u_link.inta_n_line, 1);
      check("none_pending", irq_pending, 8'h00);
      step(2);
      check("irq_gone", irq_seen, 0);
      $display("test_irq done");
   endtask

   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #50000;
      err_count++;
      tally_and_finish;
   end
   initial begin
      rst = 1'h1;
      {cfg_split, cfg_test, cfg_bscan_on, req_valid, req_write, req_cfg} = 6'h0;
      req_addr = 32'h0;
      {irq_event, irq_mask, irq_ack} = 24'h0;
      step(3);
      rst = 1'h0;
      test_modes;
      test_access(1'h0);
      test_access(1'h1);
      test_irq;
      tally_and_finish;
   end
endmodule // tb_host_bus_mode_and_irq_pins

// file: verilog/host_port_dev.sv
// Controller end: mode pins, access decode, parity and open-drain interrupt
`timescale 1ns/10ps
`include "host_port_regs.svh"

// Behaviour
// - Pull interrupt low when unmasked status active
// - Release only after acknowledge, none else pending
// - Interrupt pin changes without waiting for clock
// - Split mode: no parity, parity pin held 0
// - Split mode: chip select alone marks configuration
// - Mode pin 0 gives PCI, 1 split
// - Split mode: write/read pin gives access direction
// - PCI mode: write/read pin never driven here
// - Other pins work alike in both modes
// - Test pin high enters vendor test mode
// - Scan reset low disables boundary scan unit
// - Scan reset high or open enables scan
module host_port_dev
   import host_port_pkg::*;
#(
   parameter int IRQ_COUNT = `IRQ_COUNT_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pin side
   host_port_if.dev pins,
   // Interrupt sources
   input wire logic [IRQ_COUNT-1:0] irq_event,
   input wire logic [IRQ_COUNT-1:0] irq_mask,
   input wire logic [IRQ_COUNT-1:0] irq_ack,
   output logic [IRQ_COUNT-1:0] irq_pending,
   // Mode status
   output logic split_mode,
   output logic test_mode,
   output logic bscan_enable,
   // Decoded accesses
   output logic acc_valid,
   output logic acc_cfg,
   output logic acc_write,
   output logic [31:0] acc_addr
);

   if (IRQ_COUNT < 1 || IRQ_COUNT > 32) begin : g_bad_irq_count
      $error("host_port_dev: IRQ_COUNT must lie in 1..32");
   end

   // Split mode must hold the parity pin at logic 0, whatever the header says
   if (`PAR_SPLIT_LEVEL != 1'h0) begin : g_bad_par_level
      $error("host_port_dev: split mode parity level must be 0");
   end

   // In PCI mode direction comes from the command code alone, space from code and chip select
   if (`CMD_CFG_READ == `CMD_CFG_WRITE || `CMD_MEM_READ == `CMD_MEM_WRITE) begin : g_bad_cmd_dir
      $error("host_port_dev: read and write command codes must differ");
   end

   if (`CMD_MEM_READ == `CMD_CFG_READ || `CMD_MEM_READ == `CMD_CFG_WRITE ||
      `CMD_MEM_WRITE == `CMD_CFG_READ || `CMD_MEM_WRITE == `CMD_CFG_WRITE) begin : g_bad_cmd_space
      $error("host_port_dev: memory and configuration command codes must differ");
   end

   // PCI mode reads the direction from command bit 0 only
   if (((`CMD_CFG_READ | `CMD_MEM_READ) & 4'h1) != 4'h0 ||
      ((`CMD_CFG_WRITE & `CMD_MEM_WRITE) & 4'h1) != 4'h1) begin : g_bad_cmd_bit0
      $error("host_port_dev: write codes must be odd and read codes even");
   end

   typedef struct packed {
      dev_pins_type meta;
      dev_pins_type smp;
      mode_type mode;
      logic [IRQ_COUNT-1:0] pend;
      logic par;
      logic par_oe;
      logic test;
      logic bscan;
      logic valid;
      logic cfg;
      logic write;
      logic [31:0] addr;
   } dev_state_type;

   dev_state_type s_q;
   dev_state_type s_d;
   dev_pins_type raw;

   function automatic logic is_cfg_cmd(input logic [3:0] cmd);
      is_cfg_cmd = (cmd == `CMD_CFG_READ) || (cmd == `CMD_CFG_WRITE);
   endfunction

   // Write codes are the odd ones
   function automatic logic is_write_cmd(input logic [3:0] cmd);
      is_write_cmd = cmd[0];
   endfunction

   function automatic mode_type mode_of(input logic sel);
      mode_of = sel ? mode_split : mode_pci;
   endfunction

   // Used by decode, parity and the status output alike
   function automatic logic in_split(input mode_type m);
      in_split = (m == mode_split);
   endfunction

   // Even parity over the address phase, the same figure the host works out
   function automatic logic addr_phase_parity(input logic [31:0] ad, input logic [3:0] cmd);
      addr_phase_parity = ^{ad, cmd};
   endfunction

   // An arriving event counts as well as a held one, so the pin needs no edge
   function automatic logic irq_wanted(input logic [IRQ_COUNT-1:0] pend, input logic [IRQ_COUNT-1:0] evt,
      input logic [IRQ_COUNT-1:0] mask);
      irq_wanted = |((pend | evt) & ~mask);
   endfunction

   // Acknowledge clears, a fresh event in the same cycle wins
   function automatic logic [IRQ_COUNT-1:0] next_pending(input logic [IRQ_COUNT-1:0] pend,
      input logic [IRQ_COUNT-1:0] evt, input logic [IRQ_COUNT-1:0] ack);
      next_pending = (pend & ~ack) | evt;
   endfunction

   always_comb begin
      raw.mode_sel = pins.split_bus_mode_select;
      raw.test = pins.test_pin;
      raw.bscan_rst = pins.bscan_rst_line;
      raw.frame_n = pins.frame_n;
      raw.idsel = pins.idsel;
      raw.wr_rd = pins.wr_rd_line;
      raw.cbe = pins.cbe;
      raw.ad = pins.ad;
   end

   always_comb begin
      s_d = s_q;

      // Two-stage capture of every pin; only smp is looked at
      s_d.meta = raw;
      s_d.smp = s_q.meta;

      // Strap pins, taken as levels once synchronised
      s_d.mode = mode_of(s_q.smp.mode_sel);
      s_d.test = s_q.smp.test;
      // Pull-up on the pin makes an open input read as scan enabled
      s_d.bscan = s_q.smp.bscan_rst;

      // Interrupt status
      s_d.pend = next_pending(s_q.pend, irq_event, irq_ack);

      // Address phase decode; acc_cfg, acc_write and acc_addr hold until the next access, acc_valid lasts one cycle
      s_d.valid = 1'b0;
      if (!s_q.smp.frame_n) begin
         s_d.valid = 1'b1;
         s_d.addr = s_q.smp.ad;
         if (in_split(s_q.mode)) begin
            // No command names configuration space here, chip select alone does
            s_d.cfg = s_q.smp.idsel;
            s_d.write = s_q.smp.wr_rd;
         end else begin
            s_d.cfg = s_q.smp.idsel && is_cfg_cmd(s_q.smp.cbe);
            s_d.write = is_write_cmd(s_q.smp.cbe);
         end
      end

      // Parity goes out the cycle after the sampled address phase
      if (in_split(s_q.mode)) begin
         s_d.par = `PAR_SPLIT_LEVEL;
         s_d.par_oe = 1'b1;
      end else begin
         s_d.par = addr_phase_parity(s_q.smp.ad, s_q.smp.cbe);
         s_d.par_oe = !s_q.smp.frame_n;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
         // Frame idles high so no access is seen out of reset
         s_q.meta.frame_n <= 1'b1;
         s_q.smp.frame_n <= 1'b1;
         s_q.mode <= mode_pci;
      end else begin
         s_q <= s_d;
      end
   end

   // Interrupt line follows the event inputs directly as well as the
   // held status, so it asserts without a clock edge; it only ever sinks.
   assign pins.inta_oe = irq_wanted(s_q.pend, irq_event, irq_mask);
   // The direction pin is an input here in both modes
   assign pins.wr_rd_dev_out = 1'b0;
   assign pins.wr_rd_dev_oe = 1'b0;
   assign pins.par_out = s_q.par;
   assign pins.par_oe = s_q.par_oe;

   // Status outputs straight from the state register
   assign irq_pending = s_q.pend;
   assign split_mode = in_split(s_q.mode);
   assign test_mode = s_q.test;
   assign bscan_enable = s_q.bscan;
   assign acc_valid = s_q.valid;
   assign acc_cfg = s_q.cfg;
   assign acc_write = s_q.write;
   assign acc_addr = s_q.addr;

endmodule // host_port_dev

// file: verilog/host_port_host.sv
// Host end: drives mode pins and single accesses, watches interrupt and parity
`timescale 1ns/10ps
`include "host_port_regs.svh"

module host_port_host
   import host_port_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pin side
   host_port_if.host pins,
   // Strap settings
   input wire logic cfg_split,
   input wire logic cfg_test,
   input wire logic cfg_bscan_on,
   // Access request
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_cfg,
   input wire logic [31:0] req_addr,
   output logic req_ready,
   // Observed state
   output logic irq_seen,
   output logic par_error
);

   typedef enum logic [1:0] {st_idle, st_drive, st_wait} host_st_type;

   typedef struct packed {
      host_st_type st;
      logic [2:0] cnt;
      logic split;
      logic test;
      logic bscan;
      logic frame_n;
      logic idsel;
      logic wr_rd;
      logic wr_rd_oe;
      logic [3:0] cbe;
      logic [31:0] ad;
      logic exp_par;
      logic [1:0] irq_sync;
      logic [1:0] par_sync;
      logic par_err;
   } host_state_type;

   host_state_type s_q;
   host_state_type s_d;

   function automatic logic [3:0] pick_cmd(input logic cfg, input logic wr);
      if (cfg) begin
         pick_cmd = wr ? `CMD_CFG_WRITE : `CMD_CFG_READ;
      end else begin
         pick_cmd = wr ? `CMD_MEM_WRITE : `CMD_MEM_READ;
      end
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.irq_sync = {s_q.irq_sync[0], ~pins.inta_n_line};
      s_d.par_sync = {s_q.par_sync[0], pins.par_line};
      s_d.test = cfg_test;
      s_d.bscan = cfg_bscan_on;
      s_d.par_err = 1'b0;
      // Mode only changes while the bus is quiet
      if (s_q.st == st_idle) begin
         s_d.split = cfg_split;
      end
      s_d.wr_rd_oe = s_q.split;
      case (s_q.st)
         st_idle: begin
            if (req_valid) begin
               s_d.st = st_drive;
               s_d.frame_n = 1'b0;
               s_d.idsel = req_cfg;
               s_d.wr_rd = req_write;
               s_d.cbe = pick_cmd(req_cfg, req_write);
               s_d.ad = req_addr;
               s_d.exp_par = s_q.split ? `PAR_SPLIT_LEVEL : ^{req_addr, pick_cmd(req_cfg, req_write)};
            end
         end
         st_drive: begin
            s_d.frame_n = 1'b1;
            s_d.idsel = 1'b0;
            s_d.cnt = 3'h0;
            s_d.st = st_wait;
         end
         st_wait: begin
            s_d.cnt = s_q.cnt + 3'h1;
            // Parity launched after E3 reaches the second sync stage only at this count
            if (s_q.cnt == `PAR_CHECK_WAIT) begin
               s_d.par_err = (s_q.par_sync[1] != s_q.exp_par);
               s_d.st = st_idle;
            end
         end
         default: begin
            s_d.st = st_idle;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.st <= st_idle;
         s_q.frame_n <= 1'b1;
         s_q.par_sync <= 2'h3;
      end else begin
         s_q <= s_d;
      end
   end

   assign pins.split_bus_mode_select = s_q.split;
   assign pins.test_pin = s_q.test;
   // Driven low unless scan wanted; released high lets the pull-up enable scan
   assign pins.bscan_rst_out = 1'b0;
   assign pins.bscan_rst_oe = !s_q.bscan;
   assign pins.frame_n = s_q.frame_n;
   assign pins.idsel = s_q.idsel;
   assign pins.cbe = s_q.cbe;
   assign pins.ad = s_q.ad;
   assign pins.wr_rd_host_out = s_q.wr_rd;
   assign pins.wr_rd_host_oe = s_q.wr_rd_oe;
   assign req_ready = (s_q.st == st_idle);
   assign irq_seen = s_q.irq_sync[1];
   assign par_error = s_q.par_err;

endmodule // host_port_host

// file: verilog/host_port_if.sv
// Pin-level link between the controller end and the host end
`timescale 1ns/10ps
interface host_port_if (
   // Shared clock and reset
   input wire logic clk,
   input wire logic rst
);
   // Pins driven by the host end
   logic split_bus_mode_select;
   logic test_pin;
   logic bscan_rst_out;
   logic bscan_rst_oe;
   logic frame_n;
   logic idsel;
   logic [3:0] cbe;
   logic [31:0] ad;
   logic wr_rd_host_out;
   logic wr_rd_host_oe;
   // Pins driven by the controller end
   logic wr_rd_dev_out;
   logic wr_rd_dev_oe;
   logic par_out;
   logic par_oe;
   logic inta_oe;
   // Resolved wire levels, pull-ups where nobody drives
   logic inta_n_line;
   logic wr_rd_line;
   logic par_line;
   logic bscan_rst_line;
   assign inta_n_line = inta_oe ? 1'b0 : 1'b1;
   assign wr_rd_line = wr_rd_host_oe ? wr_rd_host_out : (wr_rd_dev_oe ? wr_rd_dev_out : 1'b1);
   assign par_line = par_oe ? par_out : 1'b1;
   assign bscan_rst_line = bscan_rst_oe ? bscan_rst_out : 1'b1;

   modport dev (
      input split_bus_mode_select, test_pin, bscan_rst_line, frame_n, idsel, cbe, ad, wr_rd_line,
      output wr_rd_dev_out, wr_rd_dev_oe, par_out, par_oe, inta_oe
   );
   modport host (
      input inta_n_line, par_line,
      output split_bus_mode_select, test_pin, bscan_rst_out, bscan_rst_oe, frame_n, idsel, cbe, ad,
      output wr_rd_host_out, wr_rd_host_oe
   );
endinterface

// file: verilog/host_port_pkg.sv
// Types shared by both ends of the host bus port
package host_port_pkg;
   typedef enum logic {mode_pci, mode_split} mode_type;
   // One sample of every pin that crosses from the far party
   typedef struct packed {
      logic mode_sel;
      logic test;
      logic bscan_rst;
      logic frame_n;
      logic idsel;
      logic wr_rd;
      logic [3:0] cbe;
      logic [31:0] ad;
   } dev_pins_type;
endpackage

// file: verilog/host_port_regs.svh
// Constants shared by both ends of the host bus port
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH
`define CMD_CFG_READ 4'hA
`define CMD_CFG_WRITE 4'hB
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define PAR_SPLIT_LEVEL 1'h0
`define PAR_CHECK_WAIT 3'h4
`define IRQ_COUNT_DEFAULT 8
`endif
